//--- wrps_pkg.sv
// Constants and types for the waveform RAM playback sequencer
package wrps_pkg;
    localparam int PCLK_MHZ    = 125;
    localparam int OSC_KHZ_X10 = 196608;
    localparam int OSC_DIV     = 20;
    localparam int WORDS       = 32768;
    localparam int ADDR_W      = 15;
    localparam int DATA_W      = 16;
    localparam int FIFO_DEPTH  = 16;
    localparam int FIFO_W      = 1 + ADDR_W + DATA_W;
    localparam int STEP_W      = 4;

    // Bus timing of the external RAMs and DACs
    localparam int RAM_ACC_NS  = 70;
    localparam int RAM_WR_NS   = 60;
    localparam int DAC_STB_NS  = 30;
    localparam int RAM_ACC_CYC = (RAM_ACC_NS * PCLK_MHZ + 999) / 1000;
    localparam int RAM_WR_CYC  = (RAM_WR_NS * PCLK_MHZ + 999) / 1000;
    localparam int DAC_STB_CYC = (DAC_STB_NS * PCLK_MHZ + 999) / 1000;

    // Carrier offset of 7.5 degrees, in tenths of a degree
    localparam int CAR_OFS_DEG_X10 = 75;
    localparam logic [ADDR_W-1:0] CAR_OFFSET =
        ADDR_W'((WORDS * CAR_OFS_DEG_X10 + 1800) / 3600);

    // Bi-phase repeats per RAM cycle: 720 Hz and 30 Hz against 30 Hz
    localparam logic [4:0] MULT_DOPPLER = 5'h18;
    localparam logic [4:0] MULT_CONV    = 5'h01;
    localparam int         COMM_LSB     = 9;

    // Register offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_RAM_ADDR = 8'h08;
    localparam logic [7:0] REG_RAM_DATA = 8'h0c;
    localparam logic [7:0] REG_MUX      = 8'h10;

    // Field positions and reset values
    localparam int CTRL_CYCLE_BIT = 0;
    localparam int RAM_SEL_BIT    = 15;
    localparam int MUX_EN_A_BIT   = 4;
    localparam int MUX_EN_B_BIT   = 5;
    localparam int ST_ADDR_LSB    = 16;
    localparam logic       CTRL_RST = 1'b0;
    localparam logic [5:0] MUX_RST  = 6'h00;

    // Synchronised pin indices
    localparam int PIN_OSC   = 0;
    localparam int PIN_STRAP = 1;
    localparam int PIN_GSC   = 2;
    localparam int PIN_AIR_N = 3;
    localparam int PIN_PEER  = 4;
    localparam int PIN_DOPP  = 5;
    localparam int NUM_PINS  = 6;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WR   = 3'b001,
        S_RD   = 3'b010,
        S_CAR  = 3'b011,
        S_CSTB = 3'b100,
        S_SB   = 3'b101,
        S_SSTB = 3'b110,
        S_SSTH = 3'b111
    } wrps_state_t;
endpackage

//--- wrps_fifo_if.sv
// Valid/ready carrier between the sequencer and its write FIFO
`timescale 1ns/10ps
interface wrps_fifo_if #(parameter int W = 32) ();
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface

//--- wrps_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module wrps_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    wrps_fifo_if.fifo f
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_ff [DEPTH];
    logic [PW:0]  wr_ptr_ff;
    logic [PW:0]  rd_ptr_ff;
    logic         full;
    logic         empty;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least 2");
    end

    assign empty        = wr_ptr_ff == rd_ptr_ff;
    assign full         = (wr_ptr_ff[PW] != rd_ptr_ff[PW]) &&
                          (wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0]);
    assign f.push_ready = !full;
    assign f.pop_valid  = !empty;
    assign f.pop_data   = mem_ff[rd_ptr_ff[PW-1:0]];

    always_ff @(posedge pclk) begin
        if (f.push_valid && !full) begin
            mem_ff[wr_ptr_ff[PW-1:0]] <= f.push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (f.push_valid && !full) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (f.pop_ready && !empty) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule

//--- wrps_top.sv
// Waveform RAM playback sequencer with APB register access
//
// Notes on behaviour
// - Host reads and writes carrier and sideband 32Kx16 RAMs through this block.
// - Host loads both RAMs, then sets cycling; words step at oscillator-derived rate.
// - While cycling, carrier words go to carrier DAC, sideband words to sideband DACs.
// - Carrier address gets 7.5 degree offset when strap fitted and ground-check high.
// - Off antenna, peer cycle-start rising edge clears the waveform address counter.
// - Bi-phase outputs repeat at 720 Hz in Doppler mode, 30 Hz otherwise.
// - Six commutator controls run only while RAM cycling is active.
// - Monitor multiplexer channel select and enables follow the host register.
// - Highest commutator control also appears as a cycle sync output.
// - Every location of both RAMs is read once per 1/30 s, oscillator divided.
// - Idle: host accesses reach the RAMs; cycling: internal counters own them.
// - Carrier DAC strobe is low while the carrier word is on the bus.
// - Sideband strobe with byte select writes low then high byte to DAC pairs.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module wrps_top
    import wrps_pkg::*;
#(
    parameter int AW    = ADDR_W,
    parameter int DW    = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  logic          pclk,
    input  logic          presetn,
    input  logic [7:0]    paddr,
    input  logic          psel,
    input  logic          penable,
    input  logic          pwrite,
    input  logic [31:0]   pwdata,
    output logic          pready,
    output logic [31:0]   prdata,
    output logic          pslverr,
    input  logic          osc_in,
    input  logic          strap_fitted,
    input  logic          ground_check_cmd,
    input  logic          on_air_indicator_n,
    input  logic          peer_cycle_sync,
    input  logic          doppler_select,
    output logic [AW-1:0] ram_addr,
    output logic [DW-1:0] ram_data_out,
    output logic          ram_data_oe_n,
    input  logic [DW-1:0] ram_data_in,
    output logic          carrier_wave_ram_cs_n,
    output logic          sideband_wave_ram_cs_n,
    output logic          ram_we_n,
    output logic          ram_oe_n,
    output logic          carrier_dac_strobe_n,
    output logic          sideband_dac_strobe_n,
    output logic          sideband_dac_byte_sel,
    output logic          sine_phase_flip_out,
    output logic          cosine_phase_flip_out,
    output logic [5:0]    commutator_ctl,
    output logic          cycle_sync_out,
    output logic [3:0]    mux_chan_sel,
    output logic          mux_a_en,
    output logic          mux_b_en
);
    if (AW != ADDR_W || DW != DATA_W || DEPTH < 2) begin : g_bad_param
        $error("Sequencer needs 15-bit addresses, 16-bit data, FIFO depth >= 2");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    wrps_fifo_if #(.W(FIFO_W)) fq ();

    logic [NUM_PINS-1:0] pins;
    logic [NUM_PINS-1:0] s1_ff;
    logic [NUM_PINS-1:0] s2_ff;
    logic [NUM_PINS-1:0] s3_ff;
    logic [NUM_PINS-1:0] pin_ff;
    logic [NUM_PINS-1:0] pin_prev_ff;
    logic [NUM_PINS-1:0] rise;
    logic [4:0]          osc_cnt_ff;
    logic                tick_ff;
    logic                ctrl_cycle_ff;
    logic                cycling_ff;
    logic                offset_on_ff;
    logic [AW-1:0]       addr_cnt_ff;
    logic [AW-1:0]       host_addr_ff;
    logic                host_sel_ff;
    logic [5:0]          mux_ff;
    wrps_state_t         state_ff;
    logic [STEP_W-1:0]   step_ff;
    logic [DW-1:0]       rd_data_ff;
    logic                rd_done_ff;
    logic                seq_done_ff;
    logic [AW-1:0]       phase;
    logic                access;
    logic                done_ok;
    logic                busy_cyc;
    logic                host_rd_go;
    logic                resync;
    logic                step_end_acc;
    logic                step_end_stb;

    // Three-stage input synchronisers, change taken when stages 2 and 3 agree
    assign pins = {doppler_select, peer_cycle_sync, on_air_indicator_n,
                   ground_check_cmd, strap_fitted, osc_in};

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_ff[g]       <= 1'b0;
                s2_ff[g]       <= 1'b0;
                s3_ff[g]       <= 1'b0;
                pin_ff[g]      <= 1'b0;
                pin_prev_ff[g] <= 1'b0;
            end else begin
                s1_ff[g] <= pins[g];
                s2_ff[g] <= s1_ff[g];
                s3_ff[g] <= s2_ff[g];
                if (s2_ff[g] == s3_ff[g]) begin
                    pin_ff[g] <= s3_ff[g];
                end
                pin_prev_ff[g] <= pin_ff[g];
            end
        end
    end

    assign rise = pin_ff & ~pin_prev_ff;

    // Word rate: oscillator divided by 20, 32768 words per 1/30 s
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_ff <= '0;
            tick_ff    <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            if (rise[PIN_OSC]) begin
                if (osc_cnt_ff == 5'(OSC_DIV - 1)) begin
                    osc_cnt_ff <= '0;
                    tick_ff    <= 1'b1;
                end else begin
                    osc_cnt_ff <= osc_cnt_ff + 5'h01;
                end
            end
        end
    end

    // Cycling starts only once queued host writes and reads are finished
    assign busy_cyc = cycling_ff || ctrl_cycle_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycling_ff   <= 1'b0;
            offset_on_ff <= 1'b0;
        end else begin
            cycling_ff <= ctrl_cycle_ff && (cycling_ff ||
                          (!fq.pop_valid && state_ff == S_IDLE));
            offset_on_ff <= pin_ff[PIN_STRAP] && pin_ff[PIN_GSC];
        end
    end

    // Waveform address counter
    assign resync = rise[PIN_PEER] && pin_ff[PIN_AIR_N];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_cnt_ff <= '0;
        end else if (!cycling_ff || resync) begin
            addr_cnt_ff <= '0;
        end else if (seq_done_ff) begin
            addr_cnt_ff <= addr_cnt_ff + 1'b1;
        end
    end

    // Bi-phase, commutator and sync outputs
    assign phase = AW'(addr_cnt_ff * (pin_ff[PIN_DOPP] ? MULT_DOPPLER : MULT_CONV));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sine_phase_flip_out   <= 1'b0;
            cosine_phase_flip_out <= 1'b0;
            commutator_ctl        <= '0;
            cycle_sync_out        <= 1'b0;
        end else if (cycling_ff) begin
            sine_phase_flip_out   <= phase[AW-1];
            cosine_phase_flip_out <= phase[AW-1] ^ phase[AW-2];
            commutator_ctl        <= addr_cnt_ff[COMM_LSB +: 6];
            cycle_sync_out        <= addr_cnt_ff[COMM_LSB + 5];
        end else begin
            sine_phase_flip_out   <= 1'b0;
            cosine_phase_flip_out <= 1'b0;
            commutator_ctl        <= '0;
            cycle_sync_out        <= 1'b0;
        end
    end

    // RAM and DAC bus sequencer
    assign access       = psel && penable;
    assign host_rd_go   = access && !pwrite && hit(paddr, REG_RAM_DATA) && !pready &&
                          !busy_cyc && !rd_done_ff && !fq.pop_valid;
    assign fq.pop_ready = (state_ff == S_IDLE) &&
                          !cycling_ff;
    assign step_end_acc = step_ff == STEP_W'(RAM_ACC_CYC - 1);
    assign step_end_stb = step_ff == STEP_W'(DAC_STB_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff               <= S_IDLE;
            step_ff                <= '0;
            ram_addr               <= '0;
            ram_data_out           <= '0;
            ram_data_oe_n          <= 1'b1;
            carrier_wave_ram_cs_n  <= 1'b1;
            sideband_wave_ram_cs_n <= 1'b1;
            ram_we_n               <= 1'b1;
            ram_oe_n               <= 1'b1;
            carrier_dac_strobe_n   <= 1'b1;
            sideband_dac_strobe_n  <= 1'b1;
            sideband_dac_byte_sel  <= 1'b0;
            rd_data_ff             <= '0;
            rd_done_ff             <= 1'b0;
            seq_done_ff            <= 1'b0;
        end else begin
            seq_done_ff <= 1'b0;
            step_ff     <= step_ff + 1'b1;
            if (access && pready) begin
                rd_done_ff <= 1'b0;
            end
            case (state_ff)
                S_IDLE: begin
                    step_ff <= '0;
                    if (cycling_ff && tick_ff) begin
                        state_ff              <= S_CAR;
                        ram_addr              <= offset_on_ff ?
                                                 addr_cnt_ff + CAR_OFFSET : addr_cnt_ff;
                        carrier_wave_ram_cs_n <= 1'b0;
                        ram_oe_n              <= 1'b0;
                    end else if (fq.pop_valid && fq.pop_ready) begin
                        state_ff               <= S_WR;
                        ram_addr               <= fq.pop_data[DW +: AW];
                        ram_data_out           <= fq.pop_data[DW-1:0];
                        ram_data_oe_n          <= 1'b0;
                        ram_we_n               <= 1'b0;
                        carrier_wave_ram_cs_n  <= fq.pop_data[FIFO_W-1];
                        sideband_wave_ram_cs_n <= !fq.pop_data[FIFO_W-1];
                    end else if (host_rd_go) begin
                        state_ff               <= S_RD;
                        ram_addr               <= host_addr_ff;
                        ram_oe_n               <= 1'b0;
                        carrier_wave_ram_cs_n  <= host_sel_ff;
                        sideband_wave_ram_cs_n <= !host_sel_ff;
                    end
                end
                S_WR: begin
                    if (step_ff == STEP_W'(RAM_WR_CYC - 1)) begin
                        state_ff               <= S_IDLE;
                        ram_we_n               <= 1'b1;
                        ram_data_oe_n          <= 1'b1;
                        carrier_wave_ram_cs_n  <= 1'b1;
                        sideband_wave_ram_cs_n <= 1'b1;
                    end
                end
                S_RD: begin
                    if (step_end_acc) begin
                        state_ff               <= S_IDLE;
                        rd_data_ff             <= ram_data_in;
                        rd_done_ff             <= 1'b1;
                        ram_oe_n               <= 1'b1;
                        carrier_wave_ram_cs_n  <= 1'b1;
                        sideband_wave_ram_cs_n <= 1'b1;
                    end
                end
                S_CAR: begin
                    if (step_end_acc) begin
                        state_ff             <= S_CSTB;
                        step_ff              <= '0;
                        carrier_dac_strobe_n <= 1'b0;
                    end
                end
                S_CSTB: begin
                    if (step_end_stb) begin
                        state_ff               <= S_SB;
                        step_ff                <= '0;
                        carrier_dac_strobe_n   <= 1'b1;
                        carrier_wave_ram_cs_n  <= 1'b1;
                        sideband_wave_ram_cs_n <= 1'b0;
                        ram_addr               <= addr_cnt_ff;
                    end
                end
                S_SB: begin
                    if (step_end_acc) begin
                        state_ff              <= S_SSTB;
                        step_ff               <= '0;
                        sideband_dac_strobe_n <= 1'b0;
                        sideband_dac_byte_sel <= 1'b0;
                    end
                end
                S_SSTB: begin
                    if (step_end_stb) begin
                        state_ff              <= S_SSTH;
                        step_ff               <= '0;
                        sideband_dac_strobe_n <= 1'b1;
                        sideband_dac_byte_sel <= 1'b1;
                    end
                end
                S_SSTH: begin
                    if (step_ff == '0) begin
                        sideband_dac_strobe_n <= 1'b0;
                    end else if (step_ff == STEP_W'(DAC_STB_CYC)) begin
                        state_ff               <= S_IDLE;
                        sideband_dac_strobe_n  <= 1'b1;
                        sideband_dac_byte_sel  <= 1'b0;
                        sideband_wave_ram_cs_n <= 1'b1;
                        ram_oe_n               <= 1'b1;
                        seq_done_ff            <= 1'b1;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // APB answer: pready in the second cycle of the access phase at the earliest
    assign done_ok = access && pready && !pslverr;
    assign fq.push_valid = done_ok && pwrite && hit(paddr, REG_RAM_DATA);
    assign fq.push_data  = {host_sel_ff, host_addr_ff, pwdata[DW-1:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (access && !pready) begin
                if (hit(paddr, REG_RAM_DATA)) begin
                    if (busy_cyc) begin
                        pready  <= 1'b1;
                        pslverr <= 1'b1;
                        prdata  <= '0;
                    end else if (pwrite) begin
                        pready <= fq.push_ready;
                    end else if (rd_done_ff) begin
                        pready <= 1'b1;
                        prdata <= {16'h0000, rd_data_ff};
                    end
                end else begin
                    pready <= 1'b1;
                    prdata <= '0;
                    if (hit(paddr, REG_CTRL)) begin
                        prdata[CTRL_CYCLE_BIT] <= ctrl_cycle_ff;
                    end else if (hit(paddr, REG_STATUS)) begin
                        prdata <= {1'b0, addr_cnt_ff, 12'h000, offset_on_ff,
                                   !fq.push_ready, !fq.pop_valid, cycling_ff};
                    end else if (hit(paddr, REG_RAM_ADDR)) begin
                        prdata <= {16'h0000, host_sel_ff, host_addr_ff};
                    end else if (hit(paddr, REG_MUX)) begin
                        prdata <= {26'h0000000, mux_ff};
                    end else begin
                        pslverr <= 1'b1;
                    end
                end
            end
        end
    end

    // Software-written registers, taken at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_cycle_ff <= CTRL_RST;
            host_addr_ff  <= '0;
            host_sel_ff   <= 1'b0;
            mux_ff        <= MUX_RST;
        end else if (done_ok) begin
            if (pwrite && hit(paddr, REG_CTRL)) begin
                ctrl_cycle_ff <= pwdata[CTRL_CYCLE_BIT];
            end
            if (pwrite && hit(paddr, REG_RAM_ADDR)) begin
                host_addr_ff <= pwdata[AW-1:0];
                host_sel_ff  <= pwdata[RAM_SEL_BIT];
            end else if (hit(paddr, REG_RAM_DATA)) begin
                host_addr_ff <= host_addr_ff + 1'b1;
            end
            if (pwrite && hit(paddr, REG_MUX)) begin
                mux_ff <= pwdata[5:0];
            end
        end
    end

    // Monitor multiplexer lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_chan_sel <= '0;
            mux_a_en     <= 1'b0;
            mux_b_en     <= 1'b0;
        end else begin
            mux_chan_sel <= mux_ff[3:0];
            mux_a_en     <= mux_ff[MUX_EN_A_BIT];
            mux_b_en     <= mux_ff[MUX_EN_B_BIT];
        end
    end

    wrps_fifo #(
        .W     (FIFO_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (fq.fifo)
    );
endmodule

//--- wrps_properties.sv
// Port assertions for the playback sequencer
`timescale 1ns/10ps
module wrps_properties (
    input logic       pclk,
    input logic       presetn,
    input logic       psel,
    input logic       penable,
    input logic       pready,
    input logic       pslverr,
    input logic       ram_we_n,
    input logic       ram_oe_n,
    input logic       ram_data_oe_n,
    input logic       carrier_wave_ram_cs_n,
    input logic       sideband_wave_ram_cs_n,
    input logic       carrier_dac_strobe_n,
    input logic       sideband_dac_strobe_n,
    input logic       sideband_dac_byte_sel,
    input logic [5:0] commutator_ctl,
    input logic       cycle_sync_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_cs_single: assert property (carrier_wave_ram_cs_n || sideband_wave_ram_cs_n)
        else $error("two rams");
    a_bus_turn: assert property (!ram_oe_n |-> ram_data_oe_n && ram_we_n)
        else $error("bus clash");
    a_write_hold: assert property ($fell(ram_we_n) |->
        (!ram_we_n && !ram_data_oe_n)[*8] ##1 ram_we_n) else $error("write length");
    a_car_strobe: assert property ($fell(carrier_dac_strobe_n) |->
        !carrier_dac_strobe_n[*4] ##1 carrier_dac_strobe_n) else $error("car strobe");
    a_sb_bytes: assert property ($fell(sideband_dac_strobe_n) && !sideband_dac_byte_sel |->
        (!sideband_dac_strobe_n && !sideband_dac_byte_sel)[*4] ##1 sideband_dac_strobe_n
        ##1 (!sideband_dac_strobe_n && sideband_dac_byte_sel)[*4]) else $error("sb strobe");
    a_sync_copy: assert property (cycle_sync_out == commutator_ctl[5]) else $error("sync");
    c_car_word: cover property ($fell(carrier_dac_strobe_n));
    c_refused: cover property (pready && pslverr);
    c_ram_write: cover property ($fell(ram_we_n));
endmodule
bind wrps_top wrps_properties u_props (.*);

//--- wrps_ram_model.sv
// Waveform RAMs and DACs on the far side of the sequencer
`timescale 1ns/10ps
module wrps_ram_model
    import wrps_pkg::*;
(
    input  logic              pclk,
    input  logic [ADDR_W-1:0] ram_addr,
    input  logic [DATA_W-1:0] ram_data_out,
    input  logic              ram_data_oe_n,
    output logic [DATA_W-1:0] ram_data_in,
    input  logic              carrier_wave_ram_cs_n,
    input  logic              sideband_wave_ram_cs_n,
    input  logic              ram_we_n,
    input  logic              ram_oe_n,
    input  logic              carrier_dac_strobe_n,
    input  logic              sideband_dac_strobe_n,
    input  logic              sideband_dac_byte_sel
);
    logic [DATA_W-1:0] car_mem [WORDS], sb_mem [WORDS];
    logic [DATA_W-1:0] last_ff = 16'h0, car_dac_ff;
    logic [7:0]        sb_lo_ff, sb_hi_ff;
    int                n_sb_ff = 0;
    wire               rd = !ram_oe_n && (carrier_wave_ram_cs_n != sideband_wave_ram_cs_n);
    wire               wr = !ram_we_n && !ram_data_oe_n;
    // Undriven bus shows the inverse of the last word
    assign ram_data_in = !rd ? ~last_ff :
        carrier_wave_ram_cs_n ? sb_mem[ram_addr] : car_mem[ram_addr];
    always @(posedge pclk) begin
        if (rd) last_ff <= ram_data_in;
        if (wr && !carrier_wave_ram_cs_n) car_mem[ram_addr] <= ram_data_out;
        if (wr && !sideband_wave_ram_cs_n) sb_mem[ram_addr] <= ram_data_out;
        if (!carrier_dac_strobe_n) car_dac_ff <= ram_data_in;
        if (!sideband_dac_strobe_n && !sideband_dac_byte_sel) sb_lo_ff <= ram_data_in[7:0];
        if (!sideband_dac_strobe_n && sideband_dac_byte_sel) sb_hi_ff <= ram_data_in[15:8];
        if (!sideband_dac_strobe_n && sideband_dac_byte_sel) n_sb_ff <= n_sb_ff + 1;
    end
endmodule

//--- test_wrps_top.sv
// Self-checking bench for the playback sequencer
`timescale 1ns/10ps
`define CHK(n, x, g) begin checks_done++; if ((g) !== (x)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module test_wrps_top
    import wrps_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic osc_in = 1'h0, strap_fitted = 1'h0, ground_check_cmd = 1'h0, doppler_select = 1'h0;
    logic on_air_indicator_n = 1'h0, peer_cycle_sync = 1'h0, e;
    logic pready, pslverr, ram_data_oe_n, carrier_wave_ram_cs_n, sideband_wave_ram_cs_n;
    logic ram_we_n, ram_oe_n, carrier_dac_strobe_n, sideband_dac_strobe_n, mux_a_en, mux_b_en;
    logic sideband_dac_byte_sel, sine_phase_flip_out, cosine_phase_flip_out, cycle_sync_out;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata, q;
    logic [ADDR_W-1:0] ram_addr;
    logic [DATA_W-1:0] ram_data_out, ram_data_in;
    logic [5:0]        commutator_ctl;
    logic [3:0]        mux_chan_sel;
    int                n_errors = 0, checks_done = 0, i;
    wrps_top DUT (.*);
    wrps_ram_model u_ram (.*);
    always #4 pclk = ~pclk;
    always begin
        repeat (2) @(posedge pclk);
        osc_in <= ~osc_in;
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wait_word();
        i = u_ram.n_sb_ff + 4;
        while (u_ram.n_sb_ff < i) @(posedge pclk);
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        repeat (8) @(posedge pclk);
        `CHK("strobe", 1'h1, carrier_dac_strobe_n)
        `CHK("comm", 6'h00, commutator_ctl)
        apb(REG_MUX, 1'h1, 32'h2a);
        apb(8'h20, 1'h0, 32'h0);
        `CHK("mux", 6'h2a, {mux_b_en, mux_a_en, mux_chan_sel})
        `CHK("unmapped", 1'h1, e)
        apb(REG_RAM_ADDR, 1'h1, 32'h0);
        for (int k = 0; k < 17; k++) apb(REG_RAM_DATA, 1'h1, 32'h1000 + k);
        apb(REG_RAM_ADDR, 1'h1, 32'h0);
        for (int k = 0; k < 17; k++) begin
            apb(REG_RAM_DATA, 1'h0, 32'h0);
            `CHK("car ram", 16'(16'h1000 + k), q[15:0])
        end
        apb(REG_RAM_ADDR, 1'h1, {16'h0, 1'h0, CAR_OFFSET});
        apb(REG_RAM_DATA, 1'h1, 32'h5a5a);
        apb(REG_RAM_ADDR, 1'h1, 32'h8000);
        apb(REG_RAM_DATA, 1'h1, 32'habcd);
        apb(REG_CTRL, 1'h1, 32'h1);
        wait_word();
        `CHK("car dac", 16'h1000, u_ram.car_dac_ff)
        `CHK("sb dac", 16'habcd, {u_ram.sb_hi_ff, u_ram.sb_lo_ff})
        `CHK("biphase", 3'h0, {sine_phase_flip_out, cosine_phase_flip_out, cycle_sync_out})
        apb(REG_RAM_DATA, 1'h0, 32'h0);
        `CHK("busy ram", 1'h1, e)
        wait_word();
        wait_word();
        on_air_indicator_n <= 1'h1;
        peer_cycle_sync <= 1'h1;
        repeat (10) @(posedge pclk);
        peer_cycle_sync <= 1'h0;
        apb(REG_STATUS, 1'h0, 32'h0);
        `CHK("cycling", 1'h1, q[0])
        `CHK("resync", 1'h1, q[30:16] < 15'h2)
        strap_fitted <= 1'h1;
        ground_check_cmd <= 1'h1;
        apb(REG_CTRL, 1'h1, 32'h0);
        do apb(REG_STATUS, 1'h0, 32'h0); while (q[0] !== 1'h0);
        apb(REG_CTRL, 1'h1, 32'h1);
        wait_word();
        `CHK("offset", 16'h5a5a, u_ram.car_dac_ff)
        report_and_stop();
    end
endmodule
